// >>> ocd_pkg.sv
// constants and types shared by the opcode decode and timing block
package ocd_pkg;

    // instruction groups handled by this block
    typedef enum logic [2:0] {
        OCD_CL_REL,
        OCD_CL_SUBR,
        OCD_CL_BTB,
        OCD_CL_BSC,
        OCD_CL_RMW,
        OCD_CL_MULT,
        OCD_CL_CTRL,
        OCD_CL_NONE
    } ocd_class_t;

    // read/modify/write, inherent and relative addressing modes
    typedef enum logic [2:0] {
        OCD_MD_ACC,
        OCD_MD_IDX,
        OCD_MD_DIR,
        OCD_MD_IX0,
        OCD_MD_IX1,
        OCD_MD_INH,
        OCD_MD_REL
    } ocd_mode_t;

    // high nibble of the opcode
    localparam logic [3:0] OCD_HI_BTB     = 4'h0;
    localparam logic [3:0] OCD_HI_BSC     = 4'h1;
    localparam logic [3:0] OCD_HI_REL     = 4'h2;
    localparam logic [3:0] OCD_HI_RMW_DIR = 4'h3;
    localparam logic [3:0] OCD_HI_RMW_ACC = 4'h4;
    localparam logic [3:0] OCD_HI_RMW_IDX = 4'h5;
    localparam logic [3:0] OCD_HI_RMW_IX1 = 4'h6;
    localparam logic [3:0] OCD_HI_RMW_IX0 = 4'h7;

    // low nibble of read/modify/write opcodes
    localparam logic [3:0] OCD_RMW_NEGATE     = 4'h0;
    localparam logic [3:0] OCD_RMW_COMPLEMENT = 4'h3;
    localparam logic [3:0] OCD_RMW_SHR_LOGIC  = 4'h4;
    localparam logic [3:0] OCD_RMW_ROT_RIGHT  = 4'h6;
    localparam logic [3:0] OCD_RMW_SHR_ARITH  = 4'h7;
    localparam logic [3:0] OCD_RMW_SHL_LOGIC  = 4'h8;
    localparam logic [3:0] OCD_RMW_ROT_LEFT   = 4'h9;
    localparam logic [3:0] OCD_RMW_DECREMENT  = 4'hA;
    localparam logic [3:0] OCD_RMW_INCREMENT  = 4'hC;
    localparam logic [3:0] OCD_RMW_TEST       = 4'hD;
    localparam logic [3:0] OCD_RMW_CLEAR      = 4'hF;

    // whole opcodes
    localparam logic [7:0] OCD_OP_MULTIPLY    = 8'h42;
    localparam logic [7:0] OCD_OP_RET_INT     = 8'h80;
    localparam logic [7:0] OCD_OP_RET_SUB     = 8'h81;
    localparam logic [7:0] OCD_OP_SW_TRAP     = 8'h83;
    localparam logic [7:0] OCD_OP_HALT        = 8'h8E;
    localparam logic [7:0] OCD_OP_IDLE_WAIT   = 8'h8F;
    localparam logic [7:0] OCD_OP_ACC_TO_IDX  = 8'h97;
    localparam logic [7:0] OCD_OP_CARRY_OFF   = 8'h98;
    localparam logic [7:0] OCD_OP_CARRY_ON    = 8'h99;
    localparam logic [7:0] OCD_OP_MASK_OFF    = 8'h9A;
    localparam logic [7:0] OCD_OP_MASK_ON     = 8'h9B;
    localparam logic [7:0] OCD_OP_STACK_RESET = 8'h9C;
    localparam logic [7:0] OCD_OP_NOTHING     = 8'h9D;
    localparam logic [7:0] OCD_OP_IDX_TO_ACC  = 8'h9F;
    localparam logic [7:0] OCD_OP_SUBR        = 8'hAD;

    // relative branch condition pairs, opcode bits 3..1
    localparam logic [2:0] OCD_PAIR_ALWAYS = 3'h0;
    localparam logic [2:0] OCD_PAIR_HIGHER = 3'h1;
    localparam logic [2:0] OCD_PAIR_CARRY  = 3'h2;
    localparam logic [2:0] OCD_PAIR_ZERO   = 3'h3;
    localparam logic [2:0] OCD_PAIR_HALF   = 3'h4;
    localparam logic [2:0] OCD_PAIR_SIGN   = 3'h5;
    localparam logic [2:0] OCD_PAIR_MASK   = 3'h6;
    localparam logic [2:0] OCD_PAIR_IRQ    = 3'h7;

    // lengths in bytes
    localparam logic [1:0] OCD_LEN_1 = 2'h1;
    localparam logic [1:0] OCD_LEN_2 = 2'h2;
    localparam logic [1:0] OCD_LEN_3 = 2'h3;

    // execution times in cpu cycles
    localparam logic [3:0] OCD_CYC_2  = 4'h2;
    localparam logic [3:0] OCD_CYC_3  = 4'h3;
    localparam logic [3:0] OCD_CYC_4  = 4'h4;
    localparam logic [3:0] OCD_CYC_5  = 4'h5;
    localparam logic [3:0] OCD_CYC_6  = 4'h6;
    localparam logic [3:0] OCD_CYC_9  = 4'h9;
    localparam logic [3:0] OCD_CYC_10 = 4'hA;
    localparam logic [3:0] OCD_CYC_11 = 4'hB;

    // cycle counter start value after the opcode byte is taken
    localparam logic [3:0] OCD_CNT_FIRST = 4'h1;
    localparam logic [3:0] OCD_CNT_STEP  = 4'h1;

endpackage

// >>> ocd_decode.sv
// opcode table: group, mode, length and cycle count of one opcode
`timescale 1ns/1ns
module ocd_decode (
    // opcode in
    input  wire logic [7:0]         opcode_i,
    // decoded fields
    output ocd_pkg::ocd_class_t     class_o,
    output ocd_pkg::ocd_mode_t      mode_o,
    output logic [1:0]              len_o,
    output logic [3:0]              cyc_o,
    output logic                    illegal_o
);
    import ocd_pkg::*;

    logic [3:0] hi;
    logic [3:0] lo;
    logic       rmw_ok;

    assign hi = opcode_i[7:4];
    assign lo = opcode_i[3:0];

    always_comb begin
        case (lo)
            OCD_RMW_NEGATE, OCD_RMW_COMPLEMENT, OCD_RMW_SHR_LOGIC, OCD_RMW_ROT_RIGHT,
            OCD_RMW_SHR_ARITH, OCD_RMW_SHL_LOGIC, OCD_RMW_ROT_LEFT, OCD_RMW_DECREMENT,
            OCD_RMW_INCREMENT, OCD_RMW_TEST, OCD_RMW_CLEAR: rmw_ok = 1'b1;
            default: rmw_ok = 1'b0;
        endcase
    end

    always_comb begin
        class_o   = OCD_CL_NONE;
        mode_o    = OCD_MD_INH;
        len_o     = OCD_LEN_1;
        cyc_o     = OCD_CYC_2;
        illegal_o = 1'b0;
        if (hi == OCD_HI_BTB) begin
            class_o = OCD_CL_BTB;
            mode_o  = OCD_MD_DIR;
            len_o   = OCD_LEN_3;
            cyc_o   = OCD_CYC_5;
        end else if (hi == OCD_HI_BSC) begin
            class_o = OCD_CL_BSC;
            mode_o  = OCD_MD_DIR;
            len_o   = OCD_LEN_2;
            cyc_o   = OCD_CYC_5;
        end else if (hi == OCD_HI_REL) begin
            class_o = OCD_CL_REL;
            mode_o  = OCD_MD_REL;
            len_o   = OCD_LEN_2;
            cyc_o   = OCD_CYC_3;
        end else if (opcode_i == OCD_OP_SUBR) begin
            class_o = OCD_CL_SUBR;
            mode_o  = OCD_MD_REL;
            len_o   = OCD_LEN_2;
            cyc_o   = OCD_CYC_6;
        end else if (opcode_i == OCD_OP_MULTIPLY) begin
            class_o = OCD_CL_MULT;
            cyc_o   = OCD_CYC_11;
        end else if (hi >= OCD_HI_RMW_DIR && hi <= OCD_HI_RMW_IX0 && rmw_ok) begin
            class_o = OCD_CL_RMW;
            case (hi)
                OCD_HI_RMW_ACC: begin
                    mode_o = OCD_MD_ACC;
                    cyc_o  = OCD_CYC_3;
                end
                OCD_HI_RMW_IDX: begin
                    mode_o = OCD_MD_IDX;
                    cyc_o  = OCD_CYC_3;
                end
                OCD_HI_RMW_DIR: begin
                    mode_o = OCD_MD_DIR;
                    len_o  = OCD_LEN_2;
                    cyc_o  = (lo == OCD_RMW_TEST) ? OCD_CYC_4 : OCD_CYC_5;
                end
                OCD_HI_RMW_IX0: begin
                    mode_o = OCD_MD_IX0;
                    cyc_o  = (lo == OCD_RMW_TEST) ? OCD_CYC_4 : OCD_CYC_5;
                end
                default: begin
                    mode_o = OCD_MD_IX1;
                    len_o  = OCD_LEN_2;
                    cyc_o  = (lo == OCD_RMW_TEST) ? OCD_CYC_5 : OCD_CYC_6;
                end
            endcase
        end else begin
            class_o = OCD_CL_CTRL;
            case (opcode_i)
                OCD_OP_SW_TRAP: cyc_o = OCD_CYC_10;
                OCD_OP_RET_INT: cyc_o = OCD_CYC_9;
                OCD_OP_RET_SUB: cyc_o = OCD_CYC_6;
                OCD_OP_CARRY_ON, OCD_OP_MASK_ON, OCD_OP_CARRY_OFF, OCD_OP_MASK_OFF,
                OCD_OP_ACC_TO_IDX, OCD_OP_IDX_TO_ACC, OCD_OP_STACK_RESET,
                OCD_OP_NOTHING, OCD_OP_HALT, OCD_OP_IDLE_WAIT: cyc_o = OCD_CYC_2;
                default: begin
                    // any other opcode is flagged illegal; here it counts as one byte
                    class_o   = OCD_CL_NONE;
                    illegal_o = 1'b1;
                end
            endcase
        end
    end

endmodule

// >>> ocd_branch.sv
// branch condition and target address for relative and bit-test branches
`timescale 1ns/1ns
module ocd_branch (
    // instruction
    input  wire ocd_pkg::ocd_class_t class_i,
    input  wire logic [7:0]          opcode_i,
    input  wire logic [7:0]          offset_i,
    input  wire logic [15:0]         next_pc_i,
    // state tested
    input  wire logic                flag_c_i,
    input  wire logic                flag_z_i,
    input  wire logic                flag_n_i,
    input  wire logic                flag_h_i,
    input  wire logic                flag_i_i,
    input  wire logic                irq_level_i,
    input  wire logic [7:0]          test_byte_i,
    // result
    output logic                     taken_o,
    output logic [15:0]              target_o
);
    import ocd_pkg::*;

    logic cond;
    logic [15:0] offs_ext;

    // even opcode of a pair branches when the condition is false
    always_comb begin
        case (opcode_i[3:1])
            OCD_PAIR_ALWAYS: cond = 1'b0;
            OCD_PAIR_HIGHER: cond = flag_c_i | flag_z_i;
            OCD_PAIR_CARRY:  cond = flag_c_i;
            OCD_PAIR_ZERO:   cond = flag_z_i;
            OCD_PAIR_HALF:   cond = flag_h_i;
            OCD_PAIR_SIGN:   cond = flag_n_i;
            OCD_PAIR_MASK:   cond = flag_i_i;
            OCD_PAIR_IRQ:    cond = irq_level_i;
            default:         cond = 1'b0;
        endcase
    end

    always_comb begin
        case (class_i)
            OCD_CL_REL:  taken_o = opcode_i[0] ? cond : ~cond;
            OCD_CL_SUBR: taken_o = 1'b1;
            // bit-test: even opcode branches on a set bit, odd on a clear bit
            OCD_CL_BTB:  taken_o = test_byte_i[opcode_i[3:1]] ^ opcode_i[0];
            default:     taken_o = 1'b0;
        endcase
    end

    assign offs_ext = {{8{offset_i[7]}}, offset_i};
    // not taken falls through to the following instruction
    assign target_o = taken_o ? next_pc_i + offs_ext : next_pc_i;

endmodule

// >>> ocd_core.sv
// opcode fetch, decode and cycle timing sequencer
`timescale 1ns/1ns
// What this block does
// - 20-2F relative branches, two bytes, three cycles
// - 22 higher, 23 lower-or-same, 20 always, 21 never
// - 24 carry clear, 25 carry set
// - 28/29 branch on half-carry clear/set
// - 2C/2D branch on mask clear/set
// - 2E/2F branch on irq low/high
// - AD subroutine branch, two bytes, six cycles
// - bit-set test branch at 2n, 3 bytes, 5 cycles
// - bit-clear test branch at 01+2n, 5 cycles
// - set/clear memory bit 10+2n/11+2n, five cycles
// - high nibble selects read/modify/write mode and timing
// - low nibble selects read/modify/write operation
// - test op is one cycle shorter in memory
// - 9B sets mask, 99 sets carry, two cycles
// - 9A clears mask, 98 clears carry, two cycles
// - 83 trap ten cycles, 80 return nine cycles
// - 81 subroutine return, one byte, six cycles
// - 97,9F,9C,9D,8E,8F one byte, two cycles
// - 42 multiplies index by accumulator, eleven cycles
module ocd_core (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    // instruction bytes from program memory
    input  wire logic                byte_valid_i,
    input  wire logic [7:0]          byte_i,
    input  wire logic [15:0]         byte_addr_i,
    output logic                     byte_ready_o,
    // core state sampled at completion
    input  wire logic                flag_c_i,
    input  wire logic                flag_z_i,
    input  wire logic                flag_n_i,
    input  wire logic                flag_h_i,
    input  wire logic                flag_i_i,
    input  wire logic                irq_level_i,
    input  wire logic [7:0]          acc_i,
    input  wire logic [7:0]          idx_i,
    input  wire logic [7:0]          test_byte_i,
    // completed instruction
    output logic                     done_o,
    output logic [7:0]               opcode_o,
    output ocd_pkg::ocd_class_t      class_o,
    output ocd_pkg::ocd_mode_t       mode_o,
    output logic [3:0]               rmw_op_o,
    output logic [1:0]               len_o,
    output logic [3:0]               cycles_o,
    output logic                     illegal_o,
    output logic [7:0]               addr_byte_o,
    output logic [2:0]               bit_idx_o,
    output logic                     bit_value_o,
    output logic                     taken_o,
    output logic [15:0]              next_pc_o,
    output logic [7:0]               prod_hi_o,
    output logic [7:0]               prod_lo_o
);
    import ocd_pkg::*;

    typedef enum logic [1:0] {
        OCD_ST_IDLE,
        OCD_ST_OPND,
        OCD_ST_EXEC
    } ocd_state_t;

    ocd_state_t  state_reg;
    ocd_state_t  state_next;
    logic [7:0]  opcode_reg;
    logic [15:0] pc_reg;
    logic [7:0]  opnd1_reg;
    logic [7:0]  opnd2_reg;
    logic [1:0]  got_reg;
    logic [3:0]  cnt_reg;

    logic [7:0]  dec_op;
    ocd_class_t  dec_class;
    ocd_mode_t   dec_mode;
    logic [1:0]  dec_len;
    logic [3:0]  dec_cyc;
    logic        dec_illegal;

    logic        take_byte;
    logic        finish;
    logic [15:0] fall_pc;
    logic [7:0]  br_offset;
    logic        br_taken;
    logic [15:0] br_target;
    logic [15:0] product;

    // in idle the arriving byte is decoded directly so its length steers the fetch
    assign dec_op = (state_reg == OCD_ST_IDLE) ? byte_i : opcode_reg;

    ocd_decode u_decode (
        .opcode_i  (dec_op),
        .class_o   (dec_class),
        .mode_o    (dec_mode),
        .len_o     (dec_len),
        .cyc_o     (dec_cyc),
        .illegal_o (dec_illegal)
    );

    // ready ignores valid, so the memory may raise valid in any cycle
    assign byte_ready_o = (state_reg == OCD_ST_IDLE) || (state_reg == OCD_ST_OPND);
    assign take_byte    = byte_ready_o && byte_valid_i;
    // last cycle of the instruction; the result appears on the following edge
    assign finish       = (state_reg == OCD_ST_EXEC) && (cnt_reg == dec_cyc - OCD_CNT_STEP);

    // address of the instruction after this one
    assign fall_pc   = pc_reg + {14'h0000, dec_len};
    // bit-test branches carry their offset in the third byte
    assign br_offset = (dec_class == OCD_CL_BTB) ? opnd2_reg : opnd1_reg;

    // flags and the tested byte are read in the last cycle, not at fetch
    ocd_branch u_branch (
        .class_i     (dec_class),
        .opcode_i    (opcode_reg),
        .offset_i    (br_offset),
        .next_pc_i   (fall_pc),
        .flag_c_i    (flag_c_i),
        .flag_z_i    (flag_z_i),
        .flag_n_i    (flag_n_i),
        .flag_h_i    (flag_h_i),
        .flag_i_i    (flag_i_i),
        .irq_level_i (irq_level_i),
        .test_byte_i (test_byte_i),
        .taken_o     (br_taken),
        .target_o    (br_target)
    );

    // operands widened first so the full 16-bit product is kept
    assign product = {8'h00, idx_i} * {8'h00, acc_i};

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            OCD_ST_IDLE: begin
                if (byte_valid_i) begin
                    state_next = (dec_len == OCD_LEN_1) ? OCD_ST_EXEC : OCD_ST_OPND;
                end
            end
            OCD_ST_OPND: begin
                if (byte_valid_i && ({1'b0, got_reg} + 3'h1 == {1'b0, dec_len})) begin
                    state_next = OCD_ST_EXEC;
                end
            end
            OCD_ST_EXEC: begin
                if (finish) begin
                    state_next = OCD_ST_IDLE;
                end
            end
            default: state_next = OCD_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= OCD_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // instruction bytes
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            opcode_reg <= 8'h00;
            pc_reg     <= 16'h0000;
            opnd1_reg  <= 8'h00;
            opnd2_reg  <= 8'h00;
            got_reg    <= 2'h0;
        end else if (take_byte) begin
            if (state_reg == OCD_ST_IDLE) begin
                opcode_reg <= byte_i;
                pc_reg     <= byte_addr_i;
                got_reg    <= OCD_LEN_1;
            end else begin
                if (got_reg == OCD_LEN_1) begin
                    opnd1_reg <= byte_i;
                end else begin
                    opnd2_reg <= byte_i;
                end
                got_reg <= got_reg + 2'h1;
            end
        end
    end

    // cycle count; a stalled operand fetch holds it so the total stays exact
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 4'h0;
        end else if (state_reg == OCD_ST_IDLE) begin
            cnt_reg <= OCD_CNT_FIRST;
        end else if (state_reg == OCD_ST_EXEC || take_byte) begin
            cnt_reg <= cnt_reg + OCD_CNT_STEP;
        end
    end

    // completion pulse
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= finish;
        end
    end

    // results of the finished instruction, held until the next one finishes
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            opcode_o    <= 8'h00;
            class_o     <= OCD_CL_NONE;
            mode_o      <= OCD_MD_INH;
            rmw_op_o    <= 4'h0;
            len_o       <= 2'h0;
            cycles_o    <= 4'h0;
            illegal_o   <= 1'b0;
            addr_byte_o <= 8'h00;
            bit_idx_o   <= 3'h0;
            bit_value_o <= 1'b0;
            taken_o     <= 1'b0;
            next_pc_o   <= 16'h0000;
        end else if (finish) begin
            opcode_o    <= opcode_reg;
            class_o     <= dec_class;
            mode_o      <= dec_mode;
            rmw_op_o    <= opcode_reg[3:0];
            len_o       <= dec_len;
            cycles_o    <= dec_cyc;
            illegal_o   <= dec_illegal;
            addr_byte_o <= opnd1_reg;
            bit_idx_o   <= opcode_reg[3:1];
            // set-bit opcodes are even, clear-bit opcodes odd
            bit_value_o <= ~opcode_reg[0];
            taken_o     <= br_taken;
            next_pc_o   <= br_target;
        end
    end

    // product: high byte to the index register, low byte to the accumulator
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prod_hi_o <= 8'h00;
            prod_lo_o <= 8'h00;
        end else if (finish && dec_class == OCD_CL_MULT) begin
            prod_hi_o <= product[15:8];
            prod_lo_o <= product[7:0];
        end
    end

    // checks
    // independent count: every busy cycle, less the cycles spent waiting for an operand
    logic [3:0] span_cnt;
    logic [3:0] gap_cnt;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || state_reg == OCD_ST_IDLE) begin
            span_cnt <= OCD_CNT_FIRST;
            gap_cnt  <= 4'h0;
        end else begin
            span_cnt <= span_cnt + OCD_CNT_STEP;
            if (state_reg == OCD_ST_OPND && !byte_valid_i) begin
                gap_cnt <= gap_cnt + OCD_CNT_STEP;
            end
        end
    end

    a_rel_timing: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && class_o == OCD_CL_REL |-> len_o == OCD_LEN_2 && cycles_o == OCD_CYC_3)
        else $error("relative branch length or time wrong");

    a_branch_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && opcode_o == 8'h22 |-> taken_o == !($past(flag_c_i) | $past(flag_z_i)))
        else $error("higher branch decision wrong");

    a_carry_pair: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && opcode_o == 8'h25 |-> taken_o == $past(flag_c_i))
        else $error("carry set branch decision wrong");

    a_half_pair: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && opcode_o == 8'h28 |-> taken_o == !$past(flag_h_i))
        else $error("half carry clear branch decision wrong");

    a_mask_pair: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && opcode_o == 8'h2D |-> taken_o == $past(flag_i_i))
        else $error("mask set branch decision wrong");

    a_irq_pair: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && opcode_o == 8'h2E |-> taken_o == !$past(irq_level_i))
        else $error("irq low branch decision wrong");

    a_subr_timing: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && opcode_o == OCD_OP_SUBR |-> taken_o && cycles_o == OCD_CYC_6)
        else $error("subroutine branch wrong");

    a_btb_timing: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && class_o == OCD_CL_BTB |-> len_o == OCD_LEN_3 && cycles_o == OCD_CYC_5)
        else $error("bit test branch length or time wrong");

    a_bsc_timing: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && class_o == OCD_CL_BSC |-> len_o == OCD_LEN_2 && cycles_o == OCD_CYC_5)
        else $error("bit set or clear length or time wrong");

    a_cycle_total: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        finish |-> span_cnt - gap_cnt + OCD_CNT_STEP == dec_cyc && got_reg == dec_len)
        else $error("instruction did not run its cycle count");

    a_test_short: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && opcode_o == 8'h3D |-> cycles_o == OCD_CYC_4)
        else $error("direct test op time wrong");

    a_trap_time: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && opcode_o == OCD_OP_SW_TRAP |-> cycles_o == OCD_CYC_10 && !illegal_o)
        else $error("software trap time wrong");

    // timings held against the package table, then bit-clear decision, product and fall-through address
    a_ix1_timing: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && class_o == OCD_CL_RMW && opcode_o[7:4] == OCD_HI_RMW_IX1 &&
            rmw_op_o != OCD_RMW_TEST |-> len_o == OCD_LEN_2 && cycles_o == OCD_CYC_6)
        else $error("offset indexed length or time wrong");

    a_flag_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && (opcode_o == OCD_OP_CARRY_ON || opcode_o == OCD_OP_MASK_ON) |->
            len_o == OCD_LEN_1 && cycles_o == OCD_CYC_2 && class_o == OCD_CL_CTRL)
        else $error("flag set op length or time wrong");

    a_btb_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && class_o == OCD_CL_BTB && opcode_o[0] |->
            taken_o == !$past(test_byte_i[opcode_reg[3:1]]))
        else $error("bit clear branch decision wrong");

    a_mult_result: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && class_o == OCD_CL_MULT |->
            {prod_hi_o, prod_lo_o} == $past(idx_i) * $past(acc_i))
        else $error("product wrong");

    a_fall_through: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        finish && !br_taken |=> next_pc_o == $past(pc_reg) + {14'h0000, $past(dec_len)})
        else $error("not taken path does not continue in line");

endmodule

// >>> ocd_prog_mem.sv
// program memory model that streams one instruction
`timescale 1ns/1ns
module ocd_prog_mem (
    // control
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       go_i,
    input  wire logic       slow_i,
    input  wire logic [1:0] cnt_i,
    input  wire logic       ready_i,
    // byte stream
    output logic            valid_o,
    output logic [7:0]      byte_o,
    output logic [15:0]     addr_o
);
    logic [7:0] mem [4];
    logic [1:0] idx_reg;
    logic [1:0] left_reg;
    // idle lines show inverted data so a stale byte cannot pass
    assign byte_o = valid_o ? mem[idx_reg] : ~mem[idx_reg];
    assign addr_o = 16'h1020 + {14'h0, idx_reg};
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            valid_o <= 1'b0;
            left_reg <= 2'h0;
            idx_reg <= 2'h0;
        end else if (go_i) begin
            left_reg <= cnt_i;
            idx_reg <= 2'h0;
            valid_o <= 1'b1;
        end else if (valid_o && ready_i) begin
            idx_reg <= idx_reg + 2'h1;
            left_reg <= left_reg - 2'h1;
            // slow mode leaves one empty cycle before each operand
            valid_o <= (left_reg > 2'h1) && !slow_i;
        end else if (left_reg != 2'h0) begin
            valid_o <= 1'b1;
        end
    end
endmodule

// >>> ocd_core_tb_top.sv
// testbench for opcode decode and timing
`timescale 1ns/1ns
module ocd_core_tb_top;
    import ocd_pkg::*;
    logic clk_i = 0, rst_n_i = 0, go = 0, slow = 0, vld, rdy, dn, ill, tk, bv;
    logic [1:0] cnt = 0, ln;
    logic [3:0] cy, rop;
    logic [2:0] bi;
    logic [5:0] fl = 0;
    logic [7:0] b, acc = 0, idx = 0, ph, pl, opo, ab, tbyte = 8'hA5;
    ocd_class_t cls;
    ocd_mode_t md;
    logic [15:0] ad, pc;
    int n_fail = 0, samples_checked = 0;
    ocd_prog_mem pm (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go), .slow_i(slow),
        .cnt_i(cnt), .ready_i(rdy), .valid_o(vld), .byte_o(b), .addr_o(ad));
    ocd_core uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .byte_valid_i(vld), .byte_i(b),
        .byte_addr_i(ad), .byte_ready_o(rdy), .flag_c_i(fl[0]), .flag_z_i(fl[1]),
        .flag_n_i(fl[2]), .flag_h_i(fl[3]), .flag_i_i(fl[4]), .irq_level_i(fl[5]),
        .acc_i(acc), .idx_i(idx), .test_byte_i(tbyte), .done_o(dn), .opcode_o(opo),
        .class_o(cls), .mode_o(md), .rmw_op_o(rop), .len_o(ln), .cycles_o(cy),
        .illegal_o(ill), .addr_byte_o(ab), .bit_idx_o(bi), .bit_value_o(bv),
        .taken_o(tk), .next_pc_o(pc), .prod_hi_o(ph), .prod_lo_o(pl));
    initial forever #25 clk_i = ~clk_i;
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // run one instruction, count cycles from opcode taken to done
    task automatic ex(input logic [7:0] op, b1, b2, input logic [1:0] l,
        input logic [3:0] c, input logic t, br, input logic [15:0] p);
        int k = 0;
        pm.mem[0] = op;
        pm.mem[1] = b1;
        pm.mem[2] = b2;
        @(posedge clk_i);
        go <= 1'b1;
        cnt <= l;
        @(posedge clk_i);
        go <= 1'b0;
        #1;
        while (!(vld && rdy) && k < 20) begin @(posedge clk_i); #1; k++; end
        k = 0;
        do begin @(posedge clk_i); #1; k++; end while (dn !== 1'b1 && k < 30);
        chk(16'(k), 16'(c) + (slow ? 16'(l) - 16'h1 : 16'h0));
        chk(cy, c);
        chk(ln, l);
        chk(ill, 0);
        chk(opo, op);
        if (l > 1) chk(ab, b1);
        chk(pc, p);
        if (br) chk(tk, t);
    endtask
    task automatic t_rel;
        logic t;
        for (int f = 0; f < 2; f++) for (int i = 0; i < 16; i++) begin
            fl <= {6{f[0]}};
            t = (i == 0) || (i != 1 && i[0] == f[0]);
            ex(8'(32 + i), 8'hF0, 0, 2, 3, t, 1, t ? 16'h1012 : 16'h1022);
        end
        ex(8'hAD, 8'h10, 0, 2, 6, 1, 1, 16'h1032);
    endtask
    // operand gaps from the memory model stretch the count
    task automatic t_bit;
        logic t;
        slow <= 1'b1;
        for (int r = 0; r < 2; r++) for (int n = 0; n < 16; n++) begin
            tbyte <= r ? 8'h5A : 8'hA5;
            t = (r ? 8'h5A : 8'hA5) >> (n / 2) ^ n;
            ex(8'(n), 8'h40, 8'h05, 3, 5, t, 1, t ? 16'h1028 : 16'h1023);
            chk(bi, 16'(n / 2));
            ex(8'(16 + n), 8'h40, 0, 2, 5, 0, 0, 16'h1022);
            chk(bv, !n[0]);
        end
        slow <= 1'b0;
    endtask
    task automatic t_rmw;
        logic [3:0] ops [11] = '{0, 3, 4, 6, 7, 8, 9, 10, 12, 13, 15};
        logic [1:0] l;
        logic [3:0] c;
        ocd_mode_t me;
        for (int m = 3; m < 8; m++) foreach (ops[j]) begin
            me = (m == 3) ? OCD_MD_DIR : (m == 6) ? OCD_MD_IX1 : OCD_MD_IX0;
            if (m == 4 || m == 5) me = (m == 4) ? OCD_MD_ACC : OCD_MD_IDX;
            l = (m == 3 || m == 6) ? 2 : 1;
            c = (m == 4 || m == 5) ? 3 : (m == 6 ? 6 : 5);
            if (ops[j] == 13 && l + c > 5) c = c - 4'h1;
            ex({m[3:0], ops[j]}, 8'h40, 0, l, c, 0, 0, 16'h1020 + 16'(l));
            chk(rop, ops[j]);
            chk(md, me);
            chk(cls, OCD_CL_RMW);
        end
    endtask
    task automatic t_ctl;
        logic [7:0] op [13] = '{8'h97, 8'h9F, 8'h99, 8'h98, 8'h9B, 8'h9A, 8'h9C,
            8'h9D, 8'h8E, 8'h8F, 8'h83, 8'h81, 8'h80};
        logic [3:0] cs [4] = '{10, 6, 9, 2};
        foreach (op[j]) ex(op[j], 0, 0, 1, cs[j < 10 ? 3 : j - 10], 0, 0, 16'h1021);
        idx <= 8'hFF;
        acc <= 8'hFE;
        ex(8'h42, 0, 0, 1, 11, 0, 0, 16'h1021);
        chk({ph, pl}, 16'hFD02);
        chk(cls, OCD_CL_MULT);
    endtask
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #600000;
        n_fail++;
        final_report;
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk({dn, rdy}, 1);
        t_rel;
        t_bit;
        t_rmw;
        t_ctl;
        final_report;
    end
endmodule
